/* File: core/sar_pkg.sv */
// constants shared by the serial converter readout frame
`default_nettype none

package sar_pkg;
    // ------------------------------------------------------------
    // frame geometry
    // ------------------------------------------------------------
    localparam int SAR_RES_BITS = 10;
    localparam int SAR_LEAD_ZEROS = 3;
    localparam int SAR_FRAME_EDGES = 16;
    localparam int SAR_TRACK_RISE = 13;
    localparam logic [4:0] SAR_CNT_RESET = 5'h00;
    // ------------------------------------------------------------
    // host timing, kept for reference by the bench
    // ------------------------------------------------------------
    localparam int SAR_CLK_PERIOD_NS = 4;
    localparam int SAR_ACQ_NS = 350;
    localparam int SAR_QUIET_NS = 50;
    localparam int SAR_ACQ_CYCLES = (SAR_ACQ_NS + SAR_CLK_PERIOD_NS - 1) / SAR_CLK_PERIOD_NS;
    localparam int SAR_QUIET_CYCLES = (SAR_QUIET_NS + SAR_CLK_PERIOD_NS - 1) / SAR_CLK_PERIOD_NS;
endpackage : sar_pkg

`default_nettype wire

/* File: core/sar_readout.sv */
// serial result framer of a clock-paced successive-approximation converter
`default_nettype none

module sar_readout #(
    parameter int RES_BITS = sar_pkg::SAR_RES_BITS
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_select_n,
    input wire logic i_serial_clk,
    input wire logic [RES_BITS-1:0] i_analog_code,
    output logic o_serial_result_out,
    output logic o_serial_result_oe_n,
    output logic o_holding,
    output logic o_acquisition_interval,
    output logic [RES_BITS-1:0] o_result
);
    import sar_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic sel_n;
    logic sck;
    logic sel_n_d_reg;
    logic sck_d_reg;

    // select idles high, clock idles low; matching reset levels avoid a false edge
    sar_sync3 u_sync_sel (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_async(i_select_n),
        .i_reset_val(1'b1),
        .o_level(sel_n)
    );
    sar_sync3 u_sync_sck (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_async(i_serial_clk),
        .i_reset_val(1'b0),
        .o_level(sck)
    );

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            sel_n_d_reg <= 1'b1;
            sck_d_reg <= 1'b0;
        end else begin
            sel_n_d_reg <= sel_n;
            sck_d_reg <= sck;
        end
    end

    logic sel_fall;
    logic sel_rise;
    logic sck_fall;
    logic sck_rise;
    assign sel_fall = sel_n_d_reg & ~sel_n;
    assign sel_rise = ~sel_n_d_reg & sel_n;
    // clock edges only count while select is low
    assign sck_fall = ~sel_n & sck_d_reg & ~sck;
    assign sck_rise = ~sel_n & ~sck_d_reg & sck;

    // ------------------------------------------------------------
    // frame state
    // ------------------------------------------------------------
    logic active_reg;
    logic [4:0] fall_cnt_reg;
    logic [4:0] rise_cnt_reg;
    logic [RES_BITS-1:0] sample_reg;
    logic [RES_BITS-1:0] sar_reg;
    logic holding_reg;
    logic out_reg;
    logic oe_n_reg;

    // edge counters restart at each select fall
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            fall_cnt_reg <= SAR_CNT_RESET;
            rise_cnt_reg <= SAR_CNT_RESET;
        end else if (sel_fall) begin
            fall_cnt_reg <= SAR_CNT_RESET;
            rise_cnt_reg <= SAR_CNT_RESET;
        end else begin
            if (sck_fall && fall_cnt_reg != 5'h1f) begin
                fall_cnt_reg <= fall_cnt_reg + 5'h01;
            end
            if (sck_rise && rise_cnt_reg != 5'h1f) begin
                rise_cnt_reg <= rise_cnt_reg + 5'h01;
            end
        end
    end

    // track/hold: hold at select fall, track at 13th rising edge
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            holding_reg <= 1'b0;
            sample_reg <= '0;
        end else if (sel_fall) begin
            holding_reg <= 1'b1;
            sample_reg <= i_analog_code;
        end else if (sck_rise && rise_cnt_reg == 5'(SAR_TRACK_RISE - 1)) begin
            holding_reg <= 1'b0;
        end
    end

    // successive approximation, one decision per falling edge of the data field
    logic [4:0] bit_pos;
    assign bit_pos = fall_cnt_reg - 5'(SAR_LEAD_ZEROS);
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            sar_reg <= '0;
        end else if (sel_fall) begin
            sar_reg <= '0;
        end else if (sck_fall && fall_cnt_reg >= 5'(SAR_LEAD_ZEROS)
                     && fall_cnt_reg < 5'(SAR_LEAD_ZEROS + RES_BITS)) begin
            sar_reg[RES_BITS-1-bit_pos] <= sample_reg[RES_BITS-1-bit_pos];
        end
    end

    // output shift: bit n of frame driven at falling edge n
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            out_reg <= 1'b0;
        end else if (sel_fall) begin
            out_reg <= 1'b0;
        end else if (sck_fall) begin
            if (fall_cnt_reg >= 5'(SAR_LEAD_ZEROS - 1)
                && fall_cnt_reg < 5'(SAR_LEAD_ZEROS + RES_BITS - 1)) begin
                out_reg <= sample_reg[RES_BITS-1-(fall_cnt_reg - 5'(SAR_LEAD_ZEROS - 1))];
            end else begin
                out_reg <= 1'b0;
            end
        end
    end

    // output enable and frame activity
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            oe_n_reg <= 1'b1;
            active_reg <= 1'b0;
        end else if (sel_fall) begin
            oe_n_reg <= 1'b0;
            active_reg <= 1'b1;
        end else if (sel_rise) begin
            oe_n_reg <= 1'b1;
            active_reg <= 1'b0;
        end else if (sck_fall && fall_cnt_reg == 5'(SAR_FRAME_EDGES - 1)) begin
            oe_n_reg <= 1'b1;
            active_reg <= 1'b0;
        end
    end

    // completed result latched at the 14th falling edge, two edges before the frame closes
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_result <= '0;
        end else if (active_reg && sck_fall && fall_cnt_reg == 5'(SAR_LEAD_ZEROS + RES_BITS)) begin
            o_result <= sar_reg;
        end
    end

    assign o_serial_result_out = out_reg;
    assign o_serial_result_oe_n = oe_n_reg;
    assign o_holding = holding_reg;
    assign o_acquisition_interval = ~holding_reg;
endmodule : sar_readout

`default_nettype wire

/* File: core/sar_sync3.sv */
// three-stage input synchroniser with agreement filter
`default_nettype none

module sar_sync3 (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_async,
    input wire logic i_reset_val,
    output logic o_level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // s1 feeds only s2; a change counts once s2 and s3 agree
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
        end else begin
            // stored relative to the idle level, so the reset branch stays constant
            s1_reg <= i_async ~^ i_reset_val;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    logic level_reg;
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            level_reg <= 1'b1;
        end else if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
        end
    end

    // i_reset_val is the pin's idle level, seen until the first agreement
    assign o_level = level_reg ~^ i_reset_val;
endmodule : sar_sync3

`default_nettype wire

/* File: tb/sar_host_model.sv */
// host serial port that frames conversions and gathers the bits
`default_nettype none
module sar_host_model (
    input wire logic i_data,
    output logic o_select_n,
    output logic o_serial_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF_NS = 24;
    initial begin
        o_select_n <= 1'b1;
        o_serial_clk <= 1'b0;
    end
    // ----
    // one frame; clock idles low and stands still between frames
    // ----
    task automatic frame(input int cycles, input logic sel, output logic [15:0] word);
        word = 16'h0000;
        o_select_n <= sel;
        #HALF_NS;
        for (int i = 0; i < cycles; i++) begin
            o_serial_clk <= 1'b1;
            #HALF_NS;
            // late in the high phase: pin sync delays the data by ~half a period
            word = {word[14:0], i_data};
            o_serial_clk <= 1'b0;
            #HALF_NS;
        end
        o_select_n <= 1'b1;
        #400;
    endtask : frame
endmodule : sar_host_model
`default_nettype wire

/* File: tb/sar_readout_asserts.sv */
// pin-level checks of the serial readout frame
`default_nettype none
module sar_readout_asserts (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_select_n,
    input wire logic i_serial_clk,
    input wire logic o_serial_result_out,
    input wire logic o_serial_result_oe_n,
    input wire logic o_holding,
    input wire logic o_acquisition_interval
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sck_reg;
    logic [4:0] rise_reg;
    logic [4:0] fall_reg;
    logic [3:0] age_reg;
    wire logic sck_rise = i_serial_clk & ~sck_reg;
    wire logic sck_fall = ~i_serial_clk & sck_reg;
    wire logic rise13 = sck_rise && rise_reg == 5'h0c && !i_select_n;
    wire logic fall16 = sck_fall && fall_reg == 5'h0f && !i_select_n;
    // ----
    // raw pin edge counts; windows of 1..8 cover the pin synchroniser
    // ----
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            sck_reg <= 1'b0;
            rise_reg <= 5'h00;
            fall_reg <= 5'h00;
            age_reg <= 4'hf;
        end else begin
            sck_reg <= i_serial_clk;
            rise_reg <= i_select_n ? 5'h00 : rise_reg + 5'(sck_rise);
            fall_reg <= i_select_n ? 5'h00 : fall_reg + 5'(sck_fall);
            age_reg <= (sck_fall || !i_select_n && rise_reg == 5'h00 && fall_reg == 5'h00 && age_reg == 4'hf) ? 4'h0
                : (age_reg == 4'hf ? age_reg : age_reg + 4'h1);
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    sequence s_sel_fall;
        $fell(i_select_n);
    endsequence
    sequence s_drive;
        ##[1:8] !o_serial_result_oe_n;
    endsequence
    drive_on_fall_a: assert property (s_sel_fall |-> s_drive)
        else $error("output not driven after select fall");
    hold_on_fall_a: assert property (s_sel_fall |-> ##[1:8] o_holding)
        else $error("no hold after select fall");
    release_on_rise_a: assert property ($rose(i_select_n) |-> ##[1:8] o_serial_result_oe_n)
        else $error("output kept driven after select rise");
    release_at_end_a: assert property (fall16 |-> ##[1:8] o_serial_result_oe_n)
        else $error("output kept driven after last falling edge");
    track_on_13_a: assert property (rise13 |-> ##[1:8] !o_holding)
        else $error("hold kept past the thirteenth rising edge");
    no_early_track_a: assert property ($fell(o_holding) && !i_select_n |-> rise_reg >= 5'h0d)
        else $error("tracking resumed early");
    acq_inverse_a: assert property (o_acquisition_interval != o_holding)
        else $error("acquisition flag disagrees with hold");
    track_while_idle_a: assert property (o_acquisition_interval && i_select_n |=> o_acquisition_interval)
        else $error("tracking ended while select high");
    idle_release_a: assert property (i_select_n [*8] |-> o_serial_result_oe_n)
        else $error("output driven while select high");
    bit_on_fall_a: assert property ($changed(o_serial_result_out) && !o_serial_result_oe_n |-> age_reg < 4'ha)
        else $error("data changed away from a falling edge");
endmodule : sar_readout_asserts
bind sar_readout sar_readout_asserts u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_select_n(i_select_n),
    .i_serial_clk(i_serial_clk), .o_serial_result_out(o_serial_result_out),
    .o_serial_result_oe_n(o_serial_result_oe_n), .o_holding(o_holding),
    .o_acquisition_interval(o_acquisition_interval));
`default_nettype wire

/* File: tb/test_serial_adc_readout_frame.sv */
// self-checking bench for the serial readout frame
`default_nettype none
module test_serial_adc_readout_frame;
    timeunit 1ns;
    timeprecision 1ps;
    import sar_pkg::*;
    localparam logic [9:0] CODES [5] = '{10'h000, 10'h3ff, 10'h2aa, 10'h155, 10'h201};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel_n, sck, sdo, oe_n, hold, acq, line;
    logic [9:0] code = 10'h000;
    logic [9:0] result;
    logic [15:0] w;
    int num_errors = 0;
    int checks = 0;
    always #2 clk = ~clk;
    // released line shows the inverse of the last driven bit, never a held value
    assign line = oe_n ? ~sdo : sdo;
    sar_readout dut (.i_sys_clk(clk), .i_reset(rst), .i_select_n(sel_n), .i_serial_clk(sck),
        .i_analog_code(code), .o_serial_result_out(sdo), .o_serial_result_oe_n(oe_n),
        .o_holding(hold), .o_acquisition_interval(acq), .o_result(result));
    sar_host_model host (.i_data(line), .o_select_n(sel_n), .o_serial_clk(sck));
    // ----
    // scenarios
    // ----
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic t_codes();
        foreach (CODES[k]) begin
            @(posedge clk) code <= CODES[k];
            fork
                host.frame(SAR_FRAME_EDGES, 1'b0, w);
                begin
                    #100;
                    check(16'(hold), 16'h0001);
                    @(posedge clk) code <= ~CODES[k];
                end
            join
            check(w, {3'h0, CODES[k], 3'h0});
            check(16'(result), 16'(CODES[k]));
            check({oe_n, hold, acq}, 16'h0005);
        end
    endtask : t_codes
    task automatic t_abort();
        @(posedge clk) code <= 10'h3c5;
        host.frame(8, 1'b0, w);
        check(w, 16'h001e);
        check(16'(oe_n), 16'h0001);
        host.frame(SAR_FRAME_EDGES, 1'b1, w);
        check(16'(oe_n), 16'h0001);
        @(posedge clk) code <= 10'h0f0;
        host.frame(SAR_FRAME_EDGES, 1'b0, w);
        check(w, {3'h0, 10'h0f0, 3'h0});
    endtask : t_abort
    task automatic finish_test();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        t_codes();
        t_abort();
        finish_test();
    end
    initial begin
        #50000;
        num_errors++;
        finish_test();
    end
endmodule : test_serial_adc_readout_frame
`default_nettype wire
